// ### logic/mps_event_flags.sv
/*
  Sticky event flags, one per event, cleared by writing one.
  Assumes set and clear come from logic on aclk.
*/
`timescale 1ns/1ps
module mps_event_flags
  import mps_pkg::*;
(
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [NUM_FLAGS-1:0] set,
  input  wire logic [NUM_FLAGS-1:0] clr,
  output logic      [NUM_FLAGS-1:0] flags
);

  logic [NUM_FLAGS-1:0] flags_q;
  logic [NUM_FLAGS-1:0] flags_d;

  // ****************************************
  // Set wins over clear
  // ****************************************
  for (genvar i = 0; i < NUM_FLAGS; i++)
  begin : g_flag
    always_comb
    begin
      flags_d[i] = (flags_q[i] & ~clr[i]) | set[i];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      flags_q <= RST_FLAGS;
    else
      flags_q <= flags_d;
  end

  assign flags = flags_q;

endmodule

// ### logic/mps_sync.sv
/*
  Two flip-flop synchronisers, one per lane.
  Assumes inputs are asynchronous to aclk; only stage two is read.
*/
`timescale 1ns/1ps
module mps_sync
  import mps_pkg::*;
#(
  parameter int W = NUM_SYNC
)(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // ****************************************
  // Per-lane stages
  // ****************************************
  for (genvar i = 0; i < W; i++)
  begin : g_lane
    always_comb
    begin
      meta_d[i] = async_in[i];
      sync_d[i] = meta_q[i];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule

// ### logic/mps_top.sv
/*
  PHY status flags, interrupt enables, management pin register,
  link monitor and station address high word, on AXI4-Lite.
  Assumes one write and one read at a time from the master; PHY pins
  are asynchronous, wake_frame_seen is a one-cycle pulse on aclk.
*/
`timescale 1ns/1ps
// Contract
// - Any edge of the synchronised link input sets the link-change flag, bit 2.
// - Writing one clears a flag; writing zero leaves it alone.
// - A recognised wake frame sets flag bit 1.
// - An illegal carrier report from the PHY sets flag bit 0.
// - All three flags are zero after reset.
// - Reserved bits of the four status-side registers read as zero.
// - Enable bit n gates interrupt reporting of flag bit n.
// - Enables reset to zero; one lets the flag raise the interrupt.
// - Pin register bit 3 reads the sampled management data pin.
// - Data-out bit drives the data pin only while direction is one.
// - Direction bit 1: zero reads, one writes; resets to zero.
// - Pin register bit 0 drives the management clock pin directly.
// - Link monitor bit 0 shows the current PHY link level.
// - Leaving reset with the link up does not set a spurious link-change flag.
// - Wake frames are recognised only while mode bit 9 is one.
// - Address-high holds station address bits 47 to 16, read/write, reset zero.
module mps_top
  import mps_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic      [1:0]        bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic      [31:0]       rdata,
  output logic      [1:0]        rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              link_status_input,
  input  wire logic              illegal_carrier_in,
  input  wire logic              wake_frame_seen,
  output logic                   wake_frame_detect_en,
  output logic                   mdc,
  input  wire logic              mdio_i,
  output logic                   mdio_o,
  output logic                   mdio_oe,
  output logic                   irq
);

  // ****************************************
  // Declarations
  // ****************************************
  logic [NUM_SYNC-1:0]  sync_s;
  logic [NUM_FLAGS-1:0] flags;
  logic [NUM_FLAGS-1:0] flag_set;
  logic [NUM_FLAGS-1:0] flag_clr;
  logic                 link_edge;
  logic                 wr_go;
  logic                 rd_go;
  logic                 aw_full_q, aw_full_d;
  logic                 w_full_q, w_full_d;
  logic [ADDR_W-1:0]    aw_addr_q, aw_addr_d;
  logic [31:0]          w_data_q, w_data_d;
  logic [3:0]           w_strb_q, w_strb_d;
  logic                 bvalid_q, bvalid_d;
  logic [1:0]           bresp_q, bresp_d;
  logic                 rvalid_q, rvalid_d;
  logic [1:0]           rresp_q, rresp_d;
  logic [31:0]          rdata_q, rdata_d;
  logic [NUM_FLAGS-1:0] en_q, en_d;
  logic [2:0]           pins_q, pins_d;
  logic                 wake_en_q, wake_en_d;
  logic [31:0]          addr_hi_q, addr_hi_d;
  logic                 link_prev_q, link_prev_d;
  logic [SETTLE_N-1:0]  settle_q, settle_d;
  logic                 irq_q, irq_d;
  logic [31:0]          addr_hi_wr;

  // ****************************************
  // Pin synchronisers and flags
  // ****************************************
  mps_sync #(.W (NUM_SYNC)) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({mdio_i, illegal_carrier_in, link_status_input}),
    .sync_out (sync_s)
  );

  mps_event_flags u_flags (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .set      (flag_set),
    .clr      (flag_clr),
    .flags    (flags)
  );

  // Edges count only once both sync stages and the copy hold real pin levels
  assign link_edge = settle_q[SETTLE_N-1] && (sync_s[SYN_LINK] != link_prev_q);

  always_comb
  begin
    flag_set               = '0;
    flag_set[FLAG_LINK]    = link_edge;
    flag_set[FLAG_WAKE]    = wake_frame_seen && wake_en_q;
    flag_set[FLAG_ILLEGAL] = sync_s[SYN_ILL];
    flag_clr               = '0;
    if (wr_go && aw_addr_q == OFS_FLAGS && w_strb_q[0])
      flag_clr = w_data_q[NUM_FLAGS-1:0];
  end

  // ****************************************
  // Bus handshakes
  // ****************************************
  assign awready = !aw_full_q;
  assign wready  = !w_full_q;
  assign arready = !rvalid_q;
  assign wr_go   = aw_full_q && w_full_q && !bvalid_q;
  assign rd_go   = arvalid && !rvalid_q;

  for (genvar b = 0; b < 4; b++)
  begin : g_byte
    assign addr_hi_wr[b*8 +: 8] = w_strb_q[b] ? w_data_q[b*8 +: 8] : addr_hi_q[b*8 +: 8];
  end

  always_comb
  begin
    aw_full_d = aw_full_q;
    aw_addr_d = aw_addr_q;
    w_full_d  = w_full_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    if (awvalid && !aw_full_q)
    begin
      aw_full_d = 1'b1;
      aw_addr_d = awaddr;
    end
    if (wvalid && !w_full_q)
    begin
      w_full_d = 1'b1;
      w_data_d = wdata;
      w_strb_d = wstrb;
    end
    if (bvalid_q && bready)
      bvalid_d = 1'b0;
    if (wr_go)
    begin
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bvalid_d  = 1'b1;
      case (aw_addr_q)
        OFS_FLAGS, OFS_IRQ_EN, OFS_PINS, OFS_LINK, OFS_ADDR_HI, OFS_MODE:
          bresp_d = RESP_OKAY;
        default:
          bresp_d = RESP_SLVERR;
      endcase
    end
  end

  // ****************************************
  // Register writes and pin state
  // ****************************************
  always_comb
  begin
    en_d        = en_q;
    pins_d      = pins_q;
    wake_en_d   = wake_en_q;
    addr_hi_d   = addr_hi_q;
    link_prev_d = sync_s[SYN_LINK];
    settle_d    = {settle_q[SETTLE_N-2:0], 1'b1};
    if (wr_go && w_strb_q[0])
    begin
      // Reserved bits are dropped, so stray ones never reach logic
      if (aw_addr_q == OFS_IRQ_EN)
        en_d = w_data_q[NUM_FLAGS-1:0];
      if (aw_addr_q == OFS_PINS)
        pins_d = w_data_q[PIN_DOUT:PIN_MDC];
    end
    if (wr_go && w_strb_q[1] && aw_addr_q == OFS_MODE)
      wake_en_d = w_data_q[MODE_WAKE_EN];
    if (wr_go && aw_addr_q == OFS_ADDR_HI)
      addr_hi_d = addr_hi_wr;
    irq_d = |(flags & en_q);
  end

  // ****************************************
  // Read data
  // ****************************************
  always_comb
  begin
    rvalid_d = rvalid_q;
    rresp_d  = rresp_q;
    rdata_d  = rdata_q;
    if (rvalid_q && rready)
      rvalid_d = 1'b0;
    if (rd_go)
    begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      rdata_d  = RST_WORD;
      case (araddr)
        OFS_FLAGS:
          rdata_d[NUM_FLAGS-1:0] = flags;
        OFS_IRQ_EN:
          rdata_d[NUM_FLAGS-1:0] = en_q;
        OFS_PINS:
          rdata_d[PIN_DIN:PIN_MDC] = {sync_s[SYN_MDIO], pins_q};
        OFS_LINK:
          rdata_d[LINK_MONITOR_BIT] = sync_s[SYN_LINK];
        OFS_ADDR_HI:
          rdata_d = addr_hi_q;
        OFS_MODE:
          rdata_d[MODE_WAKE_EN] = wake_en_q;
        default:
          rresp_d = RESP_SLVERR;
      endcase
    end
  end

  // ****************************************
  // State registers
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_q   <= 1'b0;
      aw_addr_q   <= '0;
      w_full_q    <= 1'b0;
      w_data_q    <= RST_WORD;
      w_strb_q    <= '0;
      bvalid_q    <= 1'b0;
      bresp_q     <= RESP_OKAY;
      rvalid_q    <= 1'b0;
      rresp_q     <= RESP_OKAY;
      rdata_q     <= RST_WORD;
      en_q        <= '0;
      pins_q      <= '0;
      wake_en_q   <= 1'b0;
      addr_hi_q   <= RST_WORD;
      link_prev_q <= 1'b0;
      settle_q    <= '0;
      irq_q       <= 1'b0;
    end
    else
    begin
      aw_full_q   <= aw_full_d;
      aw_addr_q   <= aw_addr_d;
      w_full_q    <= w_full_d;
      w_data_q    <= w_data_d;
      w_strb_q    <= w_strb_d;
      bvalid_q    <= bvalid_d;
      bresp_q     <= bresp_d;
      rvalid_q    <= rvalid_d;
      rresp_q     <= rresp_d;
      rdata_q     <= rdata_d;
      en_q        <= en_d;
      pins_q      <= pins_d;
      wake_en_q   <= wake_en_d;
      addr_hi_q   <= addr_hi_d;
      link_prev_q <= link_prev_d;
      settle_q    <= settle_d;
      irq_q       <= irq_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign bvalid               = bvalid_q;
  assign bresp                = bresp_q;
  assign rvalid               = rvalid_q;
  assign rresp                = rresp_q;
  assign rdata                = rdata_q;
  assign mdc                  = pins_q[PIN_MDC];
  assign mdio_o               = pins_q[PIN_DOUT];
  assign mdio_oe              = pins_q[PIN_DIR];
  assign wake_frame_detect_en = wake_en_q;
  // One cycle behind the flags, since irq comes from a flip-flop
  assign irq                  = irq_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  link_edge_set_a: assert property (
    (settle_q[SETTLE_N-1] && $changed(sync_s[SYN_LINK])) |=> flags[FLAG_LINK])
    else $error("link edge did not set flag");
  clear_by_one_a: assert property (
    (flag_clr[FLAG_WAKE] && !flag_set[FLAG_WAKE]) |=> !flags[FLAG_WAKE])
    else $error("write one did not clear wake flag");
  zero_keeps_a: assert property (
    (flags[FLAG_LINK] && !flag_clr[FLAG_LINK]) |=> flags[FLAG_LINK])
    else $error("link flag lost without a clear");
  wake_gated_a: assert property (
    (!flags[FLAG_WAKE] && !(wake_frame_seen && wake_en_q)) |=> !flags[FLAG_WAKE])
    else $error("wake flag set while detection off");
  illegal_set_a: assert property (
    sync_s[SYN_ILL] |=> flags[FLAG_ILLEGAL])
    else $error("illegal carrier did not set flag");
  reset_state_a: assert property (disable iff (1'b0)
    !aresetn |=> (flags == RST_FLAGS && en_q == '0 && !mdio_oe && !irq))
    else $error("state not cleared by reset");
  irq_follow_a: assert property ((|(flags & en_q)) |=> irq)
    else $error("irq low with an enabled flag set");
  irq_quiet_a: assert property (!(|(flags & en_q)) |=> !irq)
    else $error("irq high with no enabled flag set");
  pin_drive_a: assert property (
    (wr_go && aw_addr_q == OFS_PINS && w_strb_q[0]) |=>
      {mdio_o, mdio_oe, mdc} == $past(w_data_q[PIN_DOUT:PIN_MDC]))
    else $error("management pins disagree with written value");
  reserved_zero_a: assert property (
    (rd_go && araddr != OFS_ADDR_HI && araddr != OFS_MODE) |=> rdata[31:PIN_DIN+1] == '0)
    else $error("reserved bits read nonzero");
  link_read_a: assert property (
    (rd_go && araddr == OFS_LINK) |=> rdata[LINK_MONITOR_BIT] == $past(sync_s[SYN_LINK]))
    else $error("link monitor read wrong level");

  link_edge_c:  cover property (link_edge ##1 flags[FLAG_LINK]);
  flag_clear_c: cover property (flags[FLAG_LINK] ##1 flag_clr[FLAG_LINK] ##1 !flags[FLAG_LINK]);
  irq_rise_c:   cover property (!irq ##1 irq);
  mdio_drive_c: cover property (mdio_oe && mdio_o);

endmodule

// ### shared/mps_pkg.sv
/*
  Constants shared by the PHY status and management pin block:
  register offsets, field positions, reset values and bus answers.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package mps_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  OFS_FLAGS   = 8'h00;
  localparam logic [7:0]  OFS_IRQ_EN  = 8'h04;
  localparam logic [7:0]  OFS_PINS    = 8'h08;
  localparam logic [7:0]  OFS_LINK    = 8'h0c;
  localparam logic [7:0]  OFS_ADDR_HI = 8'h10;
  localparam logic [7:0]  OFS_MODE    = 8'h14;

  // ****************************************
  // Fields
  // ****************************************
  localparam int NUM_FLAGS    = 3;
  localparam int FLAG_ILLEGAL = 0;
  localparam int FLAG_WAKE    = 1;
  localparam int FLAG_LINK    = 2;
  localparam int PIN_MDC      = 0;
  localparam int PIN_DIR      = 1;
  localparam int PIN_DOUT     = 2;
  localparam int PIN_DIN      = 3;
  localparam int LINK_MONITOR_BIT = 0;
  localparam int MODE_WAKE_EN = 9;

  // ****************************************
  // Synchroniser lanes
  // ****************************************
  localparam int NUM_SYNC = 3;
  localparam int SYN_LINK = 0;
  localparam int SYN_ILL  = 1;
  localparam int SYN_MDIO = 2;
  // Link edges wait until both sync stages and the edge copy are refilled
  localparam int SETTLE_N = 3;

  // ****************************************
  // Reset values and bus answers
  // ****************************************
  localparam logic [31:0] RST_WORD    = 32'h0000_0000;
  localparam logic [2:0]  RST_FLAGS   = 3'h0;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage

// ### testbench/mac_phy_status_interface_tb.sv
/*
  Self-checking bench: AXI4-Lite register tasks and PHY pin scenarios.
  Assumes mps_top and the PHY model; 25 MHz aclk, synchronous reset.
*/
`timescale 1ns/1ps
module mac_phy_status_interface_tb;
  import mps_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  localparam logic [31:0] ALL = 32'hffff_ffff;
  logic              aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp;
  logic              awready, wready, bvalid, arready, rvalid, irq, wake_frame_seen;
  logic              wake_en, mdc, mdio_o, mdio_oe, mdio_line, last_bit, link, ill;
  logic              link_cmd, ill_cmd, drv_en, drv_val;
  int                fails, compares, cyc;

  mps_top u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .link_status_input(link), .illegal_carrier_in(ill), .wake_frame_seen(wake_frame_seen),
    .wake_frame_detect_en(wake_en), .mdc(mdc), .mdio_i(mdio_line), .mdio_o(mdio_o),
    .mdio_oe(mdio_oe), .irq(irq));

  mps_phy_model u_phy (.link_cmd(link_cmd), .ill_cmd(ill_cmd), .drv_en(drv_en),
    .drv_val(drv_val), .mdc(mdc), .mdio_o(mdio_o), .mdio_oe(mdio_oe), .link_status(link),
    .ill_carrier(ill), .mdio_line(mdio_line), .last_bit(last_bit));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task results;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ah, dh, bh;
    logic [1:0] r;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    bh = 1'h0;
    while (!bh)
    begin
      @(negedge aclk);
      ah = awvalid & awready;
      dh = wvalid & wready;
      bh = bvalid & bready;
      r = bresp;
      @(posedge aclk);
      if (ah) awvalid <= 1'h0;
      if (dh) wvalid <= 1'h0;
      if (bh) bready <= 1'h0;
    end
    chk({30'h0, r}, {30'h0, er});
  endtask

  // Reads until the masked word matches or the try limit runs out
  task automatic ex(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] er);
    logic ah, rh;
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 40; i++)
    begin
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      rh = 1'h0;
      while (!rh)
      begin
        @(negedge aclk);
        ah = arvalid & arready;
        rh = rvalid & rready;
        d = rdata;
        r = rresp;
        @(posedge aclk);
        if (ah) arvalid <= 1'h0;
        if (rh) rready <= 1'h0;
      end
      if ((d & m) === e) break;
    end
    chk(d & m, e);
    chk({30'h0, r}, {30'h0, er});
  endtask

  task automatic irqc(input logic e);
    repeat (2) @(negedge aclk);
    chk({31'h0, irq}, {31'h0, e});
  endtask

  task automatic pulse;
    @(posedge aclk);
    wake_frame_seen <= 1'h1;
    @(posedge aclk);
    wake_frame_seen <= 1'h0;
  endtask

  // ****************************************
  // Clock, timeout and tests
  // ****************************************
  initial
  begin
    aclk = 1'h0;
    forever #20 aclk = ~aclk;
  end

  // Longest legal run is a few hundred cycles
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      results();
    end
  end

  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, wake_frame_seen} = 7'h0;
    {link_cmd, ill_cmd, drv_en, drv_val} = 4'h0;
    awaddr = 8'h0;
    araddr = 8'h0;
    wdata = 32'h0;
    wstrb = 4'hf;
    fails = 0;
    compares = 0;
    cyc = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    ex(OFS_FLAGS, ALL, RST_WORD, RESP_OKAY);
    ex(OFS_IRQ_EN, ALL, RST_WORD, RESP_OKAY);
    ex(OFS_PINS, 32'hffff_fff7, RST_WORD, RESP_OKAY);
    ex(OFS_LINK, ALL, RST_WORD, RESP_OKAY);
    ex(OFS_ADDR_HI, ALL, RST_WORD, RESP_OKAY);
    ex(8'h18, ALL, RST_WORD, RESP_SLVERR);
    wr(8'h18, 32'h5, RESP_SLVERR);
    irqc(1'h0);
    $display("test reset done");
    wr(OFS_ADDR_HI, 32'h0123_4567, RESP_OKAY);
    ex(OFS_ADDR_HI, ALL, 32'h0123_4567, RESP_OKAY);
    wr(OFS_IRQ_EN, 32'h7, RESP_OKAY);
    ex(OFS_IRQ_EN, ALL, 32'h7, RESP_OKAY);
    wr(OFS_IRQ_EN, 32'h3, RESP_OKAY);
    $display("test registers done");
    link_cmd <= 1'h1;
    ex(OFS_FLAGS, ALL, 32'h4, RESP_OKAY);
    ex(OFS_LINK, ALL, 32'h1, RESP_OKAY);
    irqc(1'h0);
    wr(OFS_IRQ_EN, 32'h4, RESP_OKAY);
    irqc(1'h1);
    wr(OFS_FLAGS, 32'h0, RESP_OKAY);
    ex(OFS_FLAGS, ALL, 32'h4, RESP_OKAY);
    wr(OFS_FLAGS, 32'h4, RESP_OKAY);
    ex(OFS_FLAGS, ALL, 32'h0, RESP_OKAY);
    irqc(1'h0);
    link_cmd <= 1'h0;
    ex(OFS_FLAGS, ALL, 32'h4, RESP_OKAY);
    wr(OFS_FLAGS, 32'h4, RESP_OKAY);
    wr(OFS_IRQ_EN, 32'h3, RESP_OKAY);
    $display("test link done");
    ill_cmd <= 1'h1;
    ex(OFS_FLAGS, ALL, 32'h1, RESP_OKAY);
    irqc(1'h1);
    ill_cmd <= 1'h0;
    // The flag re-sets while the input is high, so let the low level arrive
    repeat (20) @(posedge aclk);
    wr(OFS_FLAGS, 32'h1, RESP_OKAY);
    ex(OFS_FLAGS, ALL, 32'h0, RESP_OKAY);
    $display("test carrier done");
    pulse();
    ex(OFS_FLAGS, ALL, 32'h0, RESP_OKAY);
    wr(OFS_MODE, 32'h200, RESP_OKAY);
    @(negedge aclk);
    chk({31'h0, wake_en}, 32'h1);
    ex(OFS_MODE, ALL, 32'h200, RESP_OKAY);
    pulse();
    ex(OFS_FLAGS, ALL, 32'h2, RESP_OKAY);
    irqc(1'h1);
    wr(OFS_FLAGS, 32'h2, RESP_OKAY);
    wr(OFS_MODE, 32'h0, RESP_OKAY);
    $display("test wake done");
    for (int w = 0; w < 8; w++)
    begin
      wr(OFS_PINS, w, RESP_OKAY);
      @(negedge aclk);
      chk({mdc, mdio_oe, mdio_line}, {w[0], w[1], w[1] ? w[2] : 1'h1});
      ex(OFS_PINS, ALL, {w[1] ? w[2] : 1'h1, w[2:0]}, RESP_OKAY);
    end
    wr(OFS_PINS, 32'h0, RESP_OKAY);
    drv_en <= 1'h1;
    ex(OFS_PINS, ALL, 32'h0, RESP_OKAY);
    drv_val <= 1'h1;
    ex(OFS_PINS, ALL, 32'h8, RESP_OKAY);
    drv_en <= 1'h0;
    for (int b = 0; b < 4; b++)
    begin
      wr(OFS_PINS, {b[0], 2'h2}, RESP_OKAY);
      wr(OFS_PINS, {b[0], 2'h3}, RESP_OKAY);
      chk({31'h0, last_bit}, {31'h0, b[0]});
    end
    $display("test pins done");
    // Reset with the link up: refilled synchronisers must not fake an edge
    link_cmd <= 1'h1;
    wr(OFS_IRQ_EN, 32'h7, RESP_OKAY);
    ex(OFS_FLAGS, ALL, 32'h4, RESP_OKAY);
    irqc(1'h1);
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (20) @(posedge aclk);
    ex(OFS_FLAGS, ALL, RST_WORD, RESP_OKAY);
    ex(OFS_IRQ_EN, ALL, RST_WORD, RESP_OKAY);
    ex(OFS_PINS, 32'hffff_fff7, RST_WORD, RESP_OKAY);
    ex(OFS_LINK, ALL, 32'h1, RESP_OKAY);
    irqc(1'h0);
    $display("test second reset done");
    results();
  end
endmodule

// ### testbench/mps_phy_model.sv
/*
  Behavioural model of the external PHY: link level, illegal carrier
  level, management data pin and a capture of written management bits.
  Assumes the bench commands levels; link and carrier levels move on the PHY's own clock.
*/
`timescale 1ns/1ps
module mps_phy_model (
  input  wire logic link_cmd,
  input  wire logic ill_cmd,
  input  wire logic drv_en,
  input  wire logic drv_val,
  input  wire logic mdc,
  input  wire logic mdio_o,
  input  wire logic mdio_oe,
  output logic      link_status,
  output logic      ill_carrier,
  output logic      mdio_line,
  output logic      last_bit
);
  // ****************************************
  // PHY clock and status levels
  // ****************************************
  logic phy_clk;
  logic oe_q;
  logic val_q;

  // Odd start offset keeps the PHY clock out of phase with aclk
  initial
  begin
    phy_clk = 1'h0;
    link_status = 1'h0;
    ill_carrier = 1'h0;
    oe_q = 1'h0;
    val_q = 1'h0;
    last_bit = 1'h0;
    #13;
    forever #160 phy_clk = ~phy_clk;
  end

  // Levels only move once per PHY period, so they stay stable for many aclk
  always @(posedge phy_clk)
  begin
    link_status <= link_cmd;
    ill_carrier <= ill_cmd;
    oe_q <= drv_en;
    val_q <= drv_val;
  end

  // Pull-up on the shared data line; PHY yields while the block drives
  assign mdio_line = mdio_oe ? mdio_o : (oe_q ? val_q : 1'h1);

  // Bits written by the block are taken on the rising management clock
  always @(posedge mdc)
    if (mdio_oe)
      last_bit <= mdio_line;
endmodule
